/* File: exc_unit_chk.sv */
// Port checker for the exception unit.
`timescale 1ns/1ps
`default_nettype none
module exc_unit_chk (
   input wire logic sys_clk, // Clock.
   input wire logic reset, // Reset.
   input wire logic boundary_valid, // Boundary.
   input wire logic access_valid, // Reference.
   input wire logic [1:0] access_kind, // Kind.
   input wire logic [1:0] access_size, // Size.
   input wire logic [63:0] access_vaddr, // Address.
   input wire logic tlb_match, // Hit.
   input wire logic tlb_entry_valid, // Valid.
   input wire logic tlb_entry_dirty, // Dirty.
   input wire logic redirect_valid, // Redirect.
   input wire logic [63:0] redirect_pc, // Handler.
   input wire logic cache_err_discard // Discard.
);
   logic useg_ok; // Aligned user-space reference off a boundary.
   assign useg_ok = access_valid && !boundary_valid && access_vaddr[63:31] == 0 && access_vaddr[2:0] == 0;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   chk_nmi_vector: assert property (cache_err_discard |-> redirect_valid &&
      redirect_pc == exc_unit_pkg::reset_vector) else $error("nmi handler wrong");
   chk_nmi_boundary: assert property ($rose(cache_err_discard) |-> $past(boundary_valid))
      else $error("nmi off boundary");
   chk_nmi_once: assert property (cache_err_discard |=> !cache_err_discard)
      else $error("nmi taken twice");
   chk_misalign_err: assert property (access_valid && !boundary_valid && access_vaddr[0] &&
      access_size != 2'h0 |=> redirect_valid && redirect_pc[8:0] == 9'h180) else $error("misalign missed");
   chk_refill_taken: assert property (useg_ok && !tlb_match |=> redirect_valid)
      else $error("refill missed");
   chk_invalid_common: assert property (useg_ok && tlb_match && !tlb_entry_valid |=>
      redirect_valid && redirect_pc[8:0] == 9'h180) else $error("invalid missed");
   chk_modified_common: assert property (useg_ok && tlb_match && tlb_entry_valid && !tlb_entry_dirty &&
      access_kind == exc_unit_pkg::kind_store |=> redirect_valid && redirect_pc[8:0] == 9'h180)
      else $error("modified missed");
   chk_unmapped_quiet: assert property (access_valid && !boundary_valid && access_vaddr[2:0] == 0 &&
      access_vaddr[63:29] == 35'h7_ffff_fffc |=> !redirect_valid) else $error("unmapped trapped");
   chk_redirect_cause: assert property (redirect_valid |-> $past(access_valid) || $past(boundary_valid))
      else $error("redirect without cause");
endmodule // exc_unit_chk
bind nmi_addr_tlb_exception_unit exc_unit_chk chk_i (.*);
`default_nettype wire

/* File: exc_unit_pkg.sv */
// Constants shared by the exception unit: register offsets, field positions, codes and vectors.
package exc_unit_pkg;

   // Register indices on the plain register port.
   localparam logic [3:0] status_offset = 4'h0;
   localparam logic [3:0] cause_offset = 4'h1;
   localparam logic [3:0] exception_return_pc_offset = 4'h2;
   localparam logic [3:0] error_return_pc_offset = 4'h3;
   localparam logic [3:0] faulting_vaddr_offset = 4'h4;
   localparam logic [3:0] context_offset = 4'h5;
   localparam logic [3:0] xcontext_offset = 4'h6;
   localparam logic [3:0] tlb_entry_high_offset = 4'h7;
   localparam logic [3:0] random_index_offset = 4'h8;

   // Status register field positions.
   localparam int exception_level_pos = 1;
   localparam int error_level_pos = 2;
   localparam int mode_lo_pos = 3;
   localparam int user_ext_pos = 5;
   localparam int supervisor_ext_pos = 6;
   localparam int kernel_ext_pos = 7;
   localparam int soft_reset_or_nmi_pos = 20;
   localparam int tlb_shutdown_pos = 21;
   localparam int boot_vector_pos = 22;

   // Cause register field positions.
   localparam int branch_delay_pos = 31;
   localparam int exc_code_lo_pos = 2;

   // Context and extended context layout.
   localparam int context_vpn_lo_pos = 4;
   localparam int context_base_lo_pos = 23;
   localparam int xcontext_region_lo_pos = 31;
   localparam int xcontext_base_lo_pos = 33;

   // Implemented virtual address bits in the extended spaces.
   localparam int va_bits = 40;
   localparam int page_pair_bit = 13;
   localparam int address_space_identifier_bits = 8;

   // Values after reset, and the floor at which the random index wraps.
   localparam logic [63:0] status_reset = 64'h0000_0000_0040_0004;
   localparam logic [5:0] random_index_top = 6'h3f;
   localparam logic [5:0] random_index_floor = 6'h00;

   // Cause codes.
   localparam logic [4:0] tlb_modified_code = 5'h01;
   localparam logic [4:0] tlb_load_miss_code = 5'h02;
   localparam logic [4:0] tlb_store_miss_code = 5'h03;
   localparam logic [4:0] load_fetch_addr_err_code = 5'h04;
   localparam logic [4:0] store_addr_err_code = 5'h05;

   // Exception vectors.
   localparam logic [63:0] reset_vector = 64'hffff_ffff_bfc0_0000;
   localparam logic [63:0] refill_vector_normal = 64'hffff_ffff_8000_0000;
   localparam logic [63:0] xrefill_vector_normal = 64'hffff_ffff_8000_0080;
   localparam logic [63:0] common_vector_normal = 64'hffff_ffff_8000_0180;
   localparam logic [63:0] refill_vector_boot = 64'hffff_ffff_bfc0_0200;
   localparam logic [63:0] xrefill_vector_boot = 64'hffff_ffff_bfc0_0280;
   localparam logic [63:0] common_vector_boot = 64'hffff_ffff_bfc0_0380;

   // Operating modes as held in the status mode field.
   localparam logic [1:0] mode_kernel = 2'h0;
   localparam logic [1:0] mode_supervisor = 2'h1;
   localparam logic [1:0] mode_user = 2'h2;

   // Access kinds and sizes from the pipeline.
   localparam logic [1:0] kind_fetch = 2'h0;
   localparam logic [1:0] kind_load = 2'h1;
   localparam logic [1:0] kind_store = 2'h2;
   localparam logic [1:0] size_half = 2'h1;
   localparam logic [1:0] size_word = 2'h2;
   localparam logic [1:0] size_double = 2'h3;

   // Address space classes.
   typedef enum logic [1:0] {
      space_user = 2'b00,
      space_supervisor = 2'b01,
      space_kernel = 2'b10
   } space_type;

endpackage

/* File: nmi_addr_tlb_exception_unit.sv */
// Exception unit for the non-maskable interrupt, address errors and TLB exceptions.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Low nmi request raises unmaskable exception
// - Take nmi only at instruction boundary
// - Nmi leaves cause register untouched
// - Nmi saves pc, sets status flags
// - Nmi jumps to reset vector
// - Nmi discards pending cache errors
// - Illegal or privileged space gives address error
// - Misaligned access gives address error
// - Address error: common vector, load/store code
// - Address error captures faulting address
// - Return pc and branch delay flag
// - Mapped miss raises tlb refill
// - Separate 32/64-bit refill vectors by space
// - Classify user and unmapped kernel spaces
// - Refill vectors only while exception level clear
// - Refill sets load or store miss code
// - Refill captures address, context and address_space_identifier
// - Random index points at a slot
// - Invalid entry raises tlb invalid exception
// - Invalid captures address, context and address_space_identifier
// - Store to clean entry raises modified
// - Modified uses common vector, modified code
module nmi_addr_tlb_exception_unit (
   input wire logic sys_clk, // Core clock.
   input wire logic reset, // Synchronous reset, active high.
   input wire logic nmi_request_n, // Non-maskable interrupt pin, active low.
   input wire logic boundary_valid, // Pipeline is at an instruction boundary.
   input wire logic [63:0] boundary_pc, // Pc of the next instruction at the boundary.
   input wire logic access_valid, // A memory reference is checked this cycle.
   input wire logic [1:0] access_kind, // Fetch, load or store.
   input wire logic [1:0] access_size, // Byte, half, word or doubleword.
   input wire logic [63:0] access_vaddr, // Virtual address of the reference.
   input wire logic [63:0] access_pc, // Pc of the referencing instruction.
   input wire logic access_in_delay_slot, // Instruction sits in a branch delay slot.
   input wire logic [63:0] branch_pc, // Pc of the preceding branch.
   input wire logic tlb_match, // A TLB entry matched the address.
   input wire logic tlb_entry_valid, // Valid bit of the matching entry.
   input wire logic tlb_entry_dirty, // Dirty bit of the matching entry.
   input wire logic [3:0] reg_addr, // Register index.
   input wire logic [63:0] reg_wdata, // Register write data.
   input wire logic reg_write, // Register write strobe.
   input wire logic reg_read, // Register read strobe.
   output logic [63:0] reg_rdata, // Register read data, one cycle after the strobe.
   output logic redirect_valid, // One-cycle pulse: fetch from redirect_pc.
   output logic [63:0] redirect_pc, // Handler address.
   output logic cache_err_discard // One-cycle pulse: drop pending cache errors.
);

   logic nmi_sync1_reg; // First synchroniser stage.
   logic nmi_sync2_reg; // Second synchroniser stage.
   logic nmi_seen_reg; // Synchronised level seen last cycle.
   logic nmi_pending_reg; // Nmi waiting for an instruction boundary.
   logic nmi_pending_next;
   logic [63:0] status_reg, status_next; // Status register.
   logic [63:0] cause_reg, cause_next; // Cause register.
   logic [63:0] epc_reg, epc_next; // Exception return pc.
   logic [63:0] error_pc_reg, error_pc_next; // Error return pc.
   logic [63:0] vaddr_reg, vaddr_next; // Faulting virtual address.
   logic [63:0] context_reg, context_next; // Context register.
   logic [63:0] xcontext_reg, xcontext_next; // Extended context register.
   logic [63:0] entry_high_reg, entry_high_next; // TLB entry high.
   logic [5:0] random_reg, random_next; // Random index.
   logic [63:0] rdata_reg, rdata_next; // Read data.
   logic redirect_reg, redirect_next; // Redirect pulse.
   logic [63:0] target_reg, target_next; // Redirect address.
   logic discard_reg, discard_next; // Cache error discard pulse.

   logic nmi_edge; // New assertion of the nmi pin.
   logic take_nmi; // Nmi taken this cycle.
   logic [1:0] cur_mode; // Effective operating mode.
   exc_unit_pkg::space_type addr_space; // Space the address lies in.
   logic addr_mapped; // Address needs translation.
   logic addr_compat; // Address lies in a 32-bit compatible segment.
   logic addr_legal; // Address lies in an implemented segment.
   logic space_ext; // Extended addressing bit of that space.
   logic privilege_err; // Mode may not reach the space.
   logic misaligned; // Alignment fault.
   logic addr_err; // Address error this cycle.
   logic refill_err; // TLB refill this cycle.
   logic invalid_err; // TLB invalid this cycle.
   logic modified_err; // TLB modified this cycle.
   logic is_store; // Reference is a store.
   logic [63:0] common_vec; // Common vector for the current boot select.

   // Two flip-flops carry the pin into the core clock domain.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         nmi_sync1_reg <= 1'b1;
         nmi_sync2_reg <= 1'b1;
         nmi_seen_reg <= 1'b1;
      end else begin
         nmi_sync1_reg <= nmi_request_n;
         nmi_sync2_reg <= nmi_sync1_reg;
         nmi_seen_reg <= nmi_sync2_reg;
      end
   end

   // single edge recognition: a falling level counts once, and a new one wins over the take.
   assign nmi_edge = nmi_seen_reg & ~nmi_sync2_reg;
   // boundary only: the request waits for the pipeline's boundary signal.
   // no mask: nothing in status gates the request.
   assign take_nmi = nmi_pending_reg & boundary_valid;
   assign nmi_pending_next = nmi_edge | (nmi_pending_reg & ~take_nmi);

   // Effective mode: exception or error level forces kernel.
   always_comb begin
      if (status_reg[exc_unit_pkg::exception_level_pos] || status_reg[exc_unit_pkg::error_level_pos]) begin
         cur_mode = exc_unit_pkg::mode_kernel;
      end else begin
         cur_mode = status_reg[exc_unit_pkg::mode_lo_pos +: 2];
      end
   end

   // space classification: decode the segment of the reference.
   always_comb begin
      addr_compat = 1'b0;
      addr_mapped = 1'b1;
      addr_legal = 1'b1;
      addr_space = exc_unit_pkg::space_kernel;
      if (access_vaddr[63:31] == 33'h0) begin
         // Low 32-bit user segment.
         addr_compat = 1'b1;
         addr_space = exc_unit_pkg::space_user;
      end else if (&access_vaddr[63:31]) begin
         // Sign-extended 32-bit kernel and supervisor segments.
         addr_compat = 1'b1;
         case (access_vaddr[30:29])
            2'b00: begin
               addr_mapped = 1'b0;
            end
            2'b01: begin
               addr_mapped = 1'b0;
            end
            2'b10: begin
               addr_space = exc_unit_pkg::space_supervisor;
            end
            default: begin
               addr_space = exc_unit_pkg::space_kernel;
            end
         endcase
      end else begin
         // Extended spaces selected by the top two address bits.
         case (access_vaddr[63:62])
            2'b00: begin
               addr_space = exc_unit_pkg::space_user;
               addr_legal = (access_vaddr[61:exc_unit_pkg::va_bits] == '0);
            end
            2'b01: begin
               addr_space = exc_unit_pkg::space_supervisor;
               addr_legal = (access_vaddr[61:exc_unit_pkg::va_bits] == '0);
            end
            2'b10: begin
               addr_mapped = 1'b0;
            end
            default: begin
               addr_legal = (access_vaddr[61:exc_unit_pkg::va_bits] == '0);
            end
         endcase
      end
   end

   // space extension bit: the faulting address's space picks the bit, not the mode.
   always_comb begin
      case (addr_space)
         exc_unit_pkg::space_user: begin
            space_ext = status_reg[exc_unit_pkg::user_ext_pos];
         end
         exc_unit_pkg::space_supervisor: begin
            space_ext = status_reg[exc_unit_pkg::supervisor_ext_pos];
         end
         default: begin
            space_ext = status_reg[exc_unit_pkg::kernel_ext_pos];
         end
      endcase
   end

   // privilege check: user reaches only user space, supervisor not kernel space.
   always_comb begin
      case (cur_mode)
         exc_unit_pkg::mode_user: begin
            privilege_err = (addr_space != exc_unit_pkg::space_user);
         end
         exc_unit_pkg::mode_supervisor: begin
            privilege_err = (addr_space == exc_unit_pkg::space_kernel);
         end
         default: begin
            privilege_err = 1'b0;
         end
      endcase
   end

   // alignment check: fetches are always word sized.
   always_comb begin
      if (access_kind == exc_unit_pkg::kind_fetch) begin
         misaligned = (access_vaddr[1:0] != 2'h0);
      end else begin
         case (access_size)
            exc_unit_pkg::size_half: begin
               misaligned = access_vaddr[0];
            end
            exc_unit_pkg::size_word: begin
               misaligned = (access_vaddr[1:0] != 2'h0);
            end
            exc_unit_pkg::size_double: begin
               misaligned = (access_vaddr[2:0] != 3'h0);
            end
            default: begin
               misaligned = 1'b0;
            end
         endcase
      end
   end

   // Exception detection in priority order: address error, refill, invalid, modified.
   always_comb begin
      is_store = (access_kind == exc_unit_pkg::kind_store);
      // illegal space: an extended address with its space bit clear is illegal too.
      addr_err = access_valid & (~addr_legal | (~addr_compat & ~space_ext) | privilege_err | misaligned);
      // refill detect: mapped reference with no matching entry.
      refill_err = access_valid & ~addr_err & addr_mapped & ~tlb_match;
      // invalid detect: matching entry with valid bit clear.
      invalid_err = access_valid & ~addr_err & addr_mapped & tlb_match & ~tlb_entry_valid;
      // modified detect: store to a valid clean entry.
      modified_err = access_valid & ~addr_err & addr_mapped & tlb_match & tlb_entry_valid & ~tlb_entry_dirty & is_store;
      if (status_reg[exc_unit_pkg::boot_vector_pos]) begin
         common_vec = exc_unit_pkg::common_vector_boot;
      end else begin
         common_vec = exc_unit_pkg::common_vector_normal;
      end
   end

   // Next register state: software writes first, hardware events override.
   always_comb begin
      status_next = status_reg;
      cause_next = cause_reg;
      epc_next = epc_reg;
      error_pc_next = error_pc_reg;
      vaddr_next = vaddr_reg;
      context_next = context_reg;
      xcontext_next = xcontext_reg;
      entry_high_next = entry_high_reg;
      redirect_next = 1'b0;
      target_next = target_reg;
      discard_next = 1'b0;
      rdata_next = 64'h0;
      // random slot: the index walks down through every slot and wraps.
      if (random_reg == exc_unit_pkg::random_index_floor) begin
         random_next = exc_unit_pkg::random_index_top;
      end else begin
         random_next = random_reg - 6'h01;
      end
      // Register reads answer one cycle later; unmapped indices read zero.
      if (reg_read) begin
         case (reg_addr)
            exc_unit_pkg::status_offset: rdata_next = status_reg;
            exc_unit_pkg::cause_offset: rdata_next = cause_reg;
            exc_unit_pkg::exception_return_pc_offset: rdata_next = epc_reg;
            exc_unit_pkg::error_return_pc_offset: rdata_next = error_pc_reg;
            exc_unit_pkg::faulting_vaddr_offset: rdata_next = vaddr_reg;
            exc_unit_pkg::context_offset: rdata_next = context_reg;
            exc_unit_pkg::xcontext_offset: rdata_next = xcontext_reg;
            exc_unit_pkg::tlb_entry_high_offset: rdata_next = entry_high_reg;
            exc_unit_pkg::random_index_offset: rdata_next = {58'h0, random_reg};
            default: rdata_next = 64'h0;
         endcase
      end
      // Register writes; the faulting address and random index are read only.
      if (reg_write) begin
         case (reg_addr)
            exc_unit_pkg::status_offset: status_next = reg_wdata;
            exc_unit_pkg::cause_offset: cause_next = reg_wdata;
            exc_unit_pkg::exception_return_pc_offset: epc_next = reg_wdata;
            exc_unit_pkg::error_return_pc_offset: error_pc_next = reg_wdata;
            exc_unit_pkg::context_offset: context_next = reg_wdata;
            exc_unit_pkg::xcontext_offset: xcontext_next = reg_wdata;
            exc_unit_pkg::tlb_entry_high_offset: entry_high_next = reg_wdata;
            default: begin
            end
         endcase
      end
      if (take_nmi) begin
         // nmi status: save pc and set flags exactly as a soft reset does.
         error_pc_next = boundary_pc;
         status_next[exc_unit_pkg::error_level_pos] = 1'b1;
         status_next[exc_unit_pkg::boot_vector_pos] = 1'b1;
         status_next[exc_unit_pkg::soft_reset_or_nmi_pos] = 1'b1;
         status_next[exc_unit_pkg::tlb_shutdown_pos] = 1'b0;
         // cause untouched: cause_next keeps its value on this path.
         // reset vector: fetch restarts at the reset address.
         redirect_next = 1'b1;
         target_next = exc_unit_pkg::reset_vector;
         // drop cache errors: one pulse to the cache error logic.
         discard_next = 1'b1;
      end else if (addr_err | refill_err | invalid_err | modified_err) begin
         // return pc: the preceding branch for a delay slot, and the flag says so.
         if (!status_reg[exc_unit_pkg::exception_level_pos]) begin
            epc_next = access_in_delay_slot ? branch_pc : access_pc;
            cause_next[exc_unit_pkg::branch_delay_pos] = access_in_delay_slot;
         end
         status_next[exc_unit_pkg::exception_level_pos] = 1'b1;
         // capture address: every group latches the faulting address.
         vaddr_next = access_vaddr;
         redirect_next = 1'b1;
         if (addr_err) begin
            // address error code: common vector, code by access type.
            cause_next[exc_unit_pkg::exc_code_lo_pos +: 5] =
               is_store ? exc_unit_pkg::store_addr_err_code : exc_unit_pkg::load_fetch_addr_err_code;
            target_next = common_vec;
         end else begin
            // refill capture and invalid capture: page number into context registers, address_space_identifier kept.
            context_next[exc_unit_pkg::context_vpn_lo_pos +: 19] = access_vaddr[31:exc_unit_pkg::page_pair_bit];
            xcontext_next[exc_unit_pkg::context_vpn_lo_pos +: 27] =
               access_vaddr[exc_unit_pkg::va_bits-1:exc_unit_pkg::page_pair_bit];
            xcontext_next[exc_unit_pkg::xcontext_region_lo_pos +: 2] = access_vaddr[63:62];
            entry_high_next = {access_vaddr[63:exc_unit_pkg::page_pair_bit], 5'h00,
                               entry_high_reg[exc_unit_pkg::address_space_identifier_bits-1:0]};
            if (modified_err) begin
               cause_next[exc_unit_pkg::exc_code_lo_pos +: 5] = exc_unit_pkg::tlb_modified_code;
               target_next = common_vec;
            end else begin
               // miss code: load/fetch or store miss, also used for invalid.
               cause_next[exc_unit_pkg::exc_code_lo_pos +: 5] =
                  is_store ? exc_unit_pkg::tlb_store_miss_code : exc_unit_pkg::tlb_load_miss_code;
               // nested refill: exception level set falls back to the common vector.
               if (invalid_err || status_reg[exc_unit_pkg::exception_level_pos]) begin
                  target_next = common_vec;
               end else if (status_reg[exc_unit_pkg::boot_vector_pos]) begin
                  // refill vector pick: extended space uses the second vector.
                  target_next = space_ext ? exc_unit_pkg::xrefill_vector_boot : exc_unit_pkg::refill_vector_boot;
               end else begin
                  target_next = space_ext ? exc_unit_pkg::xrefill_vector_normal : exc_unit_pkg::refill_vector_normal;
               end
            end
         end
      end
   end

   // Register stage for all state of the unit except the nmi synchroniser and edge-detect flip-flops.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         nmi_pending_reg <= 1'b0;
         status_reg <= exc_unit_pkg::status_reset;
         cause_reg <= 64'h0;
         epc_reg <= 64'h0;
         error_pc_reg <= 64'h0;
         vaddr_reg <= 64'h0;
         context_reg <= 64'h0;
         xcontext_reg <= 64'h0;
         entry_high_reg <= 64'h0;
         random_reg <= exc_unit_pkg::random_index_top;
         rdata_reg <= 64'h0;
         redirect_reg <= 1'b0;
         target_reg <= 64'h0;
         discard_reg <= 1'b0;
      end else begin
         nmi_pending_reg <= nmi_pending_next;
         status_reg <= status_next;
         cause_reg <= cause_next;
         epc_reg <= epc_next;
         error_pc_reg <= error_pc_next;
         vaddr_reg <= vaddr_next;
         context_reg <= context_next;
         xcontext_reg <= xcontext_next;
         entry_high_reg <= entry_high_next;
         random_reg <= random_next;
         rdata_reg <= rdata_next;
         redirect_reg <= redirect_next;
         target_reg <= target_next;
         discard_reg <= discard_next;
      end
   end

   // Outputs come straight from flip-flops.
   assign reg_rdata = rdata_reg;
   assign redirect_valid = redirect_reg;
   assign redirect_pc = target_reg;
   assign cache_err_discard = discard_reg;

endmodule // nmi_addr_tlb_exception_unit

`default_nettype wire

/* File: nmi_source.sv */
// Model of the system logic that asserts the nmi pin.
`timescale 1ns/1ps
`default_nettype none
module nmi_source (
   input wire logic sys_clk, // Clock.
   input wire logic fire, // Start one assertion.
   output logic nmi_request_n // Pin, active low.
);
   int low_cnt = 0; // Cycles the pin stays low.
   always @(posedge sys_clk) begin
      if (fire) low_cnt <= 4;
      else if (low_cnt > 0) low_cnt <= low_cnt - 1;
   end
   assign nmi_request_n = (low_cnt == 0);
endmodule // nmi_source
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the exception unit.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic sys_clk, reset, fire, boundary_valid, access_valid, access_in_delay_slot, tlb_match, reg_write;
   logic tlb_entry_valid, tlb_entry_dirty, reg_read, nmi_request_n, redirect_valid, cache_err_discard;
   logic [1:0] access_kind, access_size;
   logic [3:0] reg_addr;
   logic [63:0] boundary_pc, access_vaddr, access_pc, branch_pc, reg_wdata, reg_rdata, redirect_pc, rd, va;
   logic [31:0] rnd = 32'h859d2904; // Random state.
   int error_cnt = 0;
   int samples_checked = 0;
   logic [1:0] kd [7] = '{2'h2, 2'h1, 2'h2, 2'h0, 2'h2, 2'h1, 2'h1}; // Kind per case.
   logic [4:0] cd [7] = '{5'h05, 5'h02, 5'h03, 5'h02, 5'h01, 5'h02, 5'h02}; // Code per case.
   logic [6:0] mt = 7'h19; // Entry hit per case.
   nmi_addr_tlb_exception_unit dut (.*);
   nmi_source src (.*);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic cmp(input string n, input logic [63:0] e, input logic [63:0] s);
      samples_checked++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rdr(input logic [3:0] a);
      @(posedge sys_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 rd = reg_rdata;
   endtask
   task automatic acc(input int i);
      va = {32'h0, rnd & 32'h7fff_fff8} | (i == 0 ? 64'h1 : 64'h0);
      if (i == 6) va[63:29] = 35'h7_ffff_fffc;
      @(posedge sys_clk);
      access_valid <= 1'b1;
      access_kind <= kd[i];
      access_size <= (i == 0) ? 2'h2 : 2'h3;
      access_vaddr <= va;
      access_pc <= {rnd, rnd};
      branch_pc <= {rnd, ~rnd};
      access_in_delay_slot <= i[0];
      tlb_match <= mt[i];
      // entry replaced valid: software restores the valid bit after case 3.
      tlb_entry_valid <= (i == 0 || i == 4);
      tlb_entry_dirty <= (i == 0);
      @(posedge sys_clk);
      access_valid <= 1'b0;
      #1 cmp("redirect_valid", i < 6, redirect_valid);
   endtask
   task automatic final_report;
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Watchdog: the sequence needs about 120 cycles.
   initial begin
      #50000;
      error_cnt++;
      final_report();
   end
   initial begin
      {fire, boundary_valid, access_valid, access_in_delay_slot, tlb_match, tlb_entry_valid, tlb_entry_dirty, reg_write,
         reg_read, access_kind, access_size, reg_addr, boundary_pc, access_vaddr, access_pc, branch_pc, reg_wdata} = '0;
      reset = 1'b1;
      repeat (5) @(posedge sys_clk);
      reset <= 1'b0;
      rdr(4'h0);
      cmp("status", exc_unit_pkg::status_reset, rd);
      rdr(4'hf);
      cmp("unmapped", 64'h0, rd);
      // Case 5 keeps exception level set from case 4.
      for (int i = 0; i < 7; i++) begin
         rnd = lfsr(rnd);
         if (i != 5) begin
            @(posedge sys_clk);
            reg_write <= 1'b1;
            reg_addr <= 4'h0;
            reg_wdata <= (i == 2) ? 64'h20 : 64'h40_0000;
            @(posedge sys_clk);
            reg_write <= 1'b0;
         end
         acc(i);
         if (i < 6) cmp("redirect_pc", (i == 1) ? exc_unit_pkg::refill_vector_boot : (i == 2) ?
            exc_unit_pkg::xrefill_vector_normal : exc_unit_pkg::common_vector_boot, redirect_pc);
         rdr(4'h1);
         cmp("cause code", cd[i], rd[6:2]);
         if (i < 5) cmp("branch delay", i[0], rd[31]);
         rdr(4'h2);
         if (i < 5) cmp("return pc", i[0] ? {rnd, ~rnd} : {rnd, rnd}, rd);
         rdr(4'h4);
         if (i < 6) cmp("faulting vaddr", va, rd);
         rdr(4'h7);
         if (i > 0 && i < 6) cmp("entry high", va[63:13], rd[63:13]);
         rdr(4'h8);
         cmp("random index", 64'h0, rd >> 6);
      end
      @(posedge sys_clk);
      fire <= 1'b1;
      boundary_pc <= {~rnd, rnd};
      @(posedge sys_clk);
      fire <= 1'b0;
      repeat (6) @(posedge sys_clk);
      boundary_valid <= 1'b1;
      repeat (8) begin
         @(posedge sys_clk);
         #1 if (redirect_valid === 1'b1) break;
      end
      cmp("discard", 64'h1, cache_err_discard);
      cmp("nmi pc", exc_unit_pkg::reset_vector, redirect_pc);
      rdr(4'h0);
      cmp("nmi status", 64'h50_0004, rd & 64'h70_0004);
      rdr(4'h3);
      cmp("error pc", {~rnd, rnd}, rd);
      rdr(4'h1);
      cmp("cause kept", 64'h2, rd[6:2]);
      final_report();
   end
endmodule // tb_top
`default_nettype wire
